// >>> hdl/pftc_defines.svh
// Purpose: offsets, field positions, reset values of the trip/capture block
// Assumes: apb byte addresses, one 32-bit word per register
// Notes:   definitions only
`ifndef PFTC_DEFINES_SVH
`define PFTC_DEFINES_SVH

`define PFTC_OFF_TRIP_CFG    12'h000
`define PFTC_OFF_TRIP_ACT    12'h004
`define PFTC_OFF_TRIP_SW     12'h008
`define PFTC_OFF_TRIP_STAT   12'h00C
`define PFTC_OFF_CAP_TCFG    12'h010
`define PFTC_OFF_CAP_PHASE   12'h014
`define PFTC_OFF_CAP_CH0CFG  12'h018
`define PFTC_OFF_CAP_TS0     12'h024
`define PFTC_OFF_CAP_STAT    12'h030
`define PFTC_OFF_CAP_TIMER   12'h034

// trip_cfg fields
`define PFTC_CFG_CYC_EN_LSB  0
`define PFTC_CFG_OST_EN_LSB  3
`define PFTC_CFG_REL_LSB     6
`define PFTC_CFG_CLR_BIT     8
// capture channel config fields
`define PFTC_CCFG_EN_BIT     0
`define PFTC_CCFG_INV_BIT    1
`define PFTC_CCFG_RISE_BIT   2
`define PFTC_CCFG_FALL_BIT   3
`define PFTC_CCFG_PRE_LSB    8
`define PFTC_CCFG_SWCAP_BIT  16
// capture timer config fields
`define PFTC_TCFG_EN_BIT     0
`define PFTC_TCFG_SYEN_BIT   1
`define PFTC_TCFG_SWSY_BIT   2

`define PFTC_RST_WORD        32'h0000_0000
`define PFTC_ACT_NONE        2'h0

`endif

// >>> hdl/pftc_pkg.sv
// Purpose: shared types of the trip/capture block
// Assumes: nothing
// Notes:   action codes match 2-bit action fields
`default_nettype none
package pftc_pkg;
    typedef enum logic [1:0] {
        PFTC_ACT_HOLD = 2'h0,
        PFTC_ACT_LOW  = 2'h1,
        PFTC_ACT_HIGH = 2'h2,
        PFTC_ACT_TOG  = 2'h3
    } pftc_act_t;

    typedef enum logic [1:0] {
        PFTC_REL_ZERO_UP   = 2'h0,
        PFTC_REL_ZERO_DOWN = 2'h1,
        PFTC_REL_PER_UP    = 2'h2,
        PFTC_REL_PER_DOWN  = 2'h3
    } pftc_rel_t;
endpackage : pftc_pkg
`default_nettype wire

// >>> hdl/pftc_cap_if.sv
// Purpose: carries one capture channel's config and result
// Assumes: single clock domain
// Notes:   used between top and capture channel
`timescale 1ns/100ps
`default_nettype none
interface pftc_cap_if;
    logic        enable;
    logic        invert;
    logic        on_rise;
    logic        on_fall;
    logic [7:0]  prescale;
    logic        sw_capture;
    logic        event_pulse;
    logic        edge_falling;
    logic [31:0] stamp;
    modport top (output enable, invert, on_rise, on_fall, prescale,
                 sw_capture, input event_pulse, edge_falling, stamp);
    modport chan (input enable, invert, on_rise, on_fall, prescale,
                  sw_capture, output event_pulse, edge_falling, stamp);
endinterface : pftc_cap_if
`default_nettype wire

// >>> hdl/pftc_cap_chan.sv
// Purpose: one capture channel: invert, prescale, edge select, stamp
// Assumes: cap_in already synchronised
// Notes:   prescale 0..255 means ratio 1..256
`timescale 1ns/100ps
`default_nettype none
`include "pftc_defines.svh"
module pftc_cap_chan (
    input  wire logic        mclk_in,     // clock
    input  wire logic        rst_n_in,    // async reset, low
    input  wire logic        cap_in,      // synced capture input
    input  wire logic [31:0] timer_in,    // capture time base
    pftc_cap_if.chan         cfg          // config and result
);
    logic       lvl_r, lvl_nxt;
    logic [7:0] cnt_r, cnt_nxt;
    logic       pre_r, pre_nxt;
    logic       ev_r, ev_nxt;
    logic       fall_r, fall_nxt;
    logic [31:0] ts_r, ts_nxt;
    logic       inv_lvl;

    always_comb
    begin
        inv_lvl  = cap_in ^ cfg.invert;
        lvl_nxt  = inv_lvl;
        cnt_nxt  = cnt_r;
        pre_nxt  = pre_r;
        ev_nxt   = 1'b0;
        fall_nxt = fall_r;
        ts_nxt   = ts_r;
        if (!cfg.enable)
        begin
            cnt_nxt = 8'h00;
            pre_nxt = inv_lvl;
        end
        else if (inv_lvl != lvl_r)
        begin
            // prescaled signal flips every prescale+1 raw edges
            if (cnt_r == cfg.prescale)
            begin
                cnt_nxt = 8'h00;
                pre_nxt = ~pre_r;
                if ((!pre_r && cfg.on_rise) || (pre_r && cfg.on_fall))
                begin
                    ev_nxt   = 1'b1;
                    fall_nxt = pre_r;
                    ts_nxt   = timer_in;
                end
            end
            else
                cnt_nxt = cnt_r + 8'h01;
        end
        if (cfg.sw_capture)
        begin
            ev_nxt = 1'b1;
            ts_nxt = timer_in;
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            lvl_r  <= 1'b0;
            cnt_r  <= 8'h00;
            pre_r  <= 1'b0;
            ev_r   <= 1'b0;
            fall_r <= 1'b0;
            ts_r   <= `PFTC_RST_WORD;
        end
        else
        begin
            lvl_r  <= lvl_nxt;
            cnt_r  <= cnt_nxt;
            pre_r  <= pre_nxt;
            ev_r   <= ev_nxt;
            fall_r <= fall_nxt;
            ts_r   <= ts_nxt;
        end
    end

    assign cfg.event_pulse  = ev_r;
    assign cfg.edge_falling = fall_r;
    assign cfg.stamp        = ts_r;
endmodule : pftc_cap_chan
`default_nettype wire

// >>> hdl/pftc_trip_out.sv
// Purpose: applies trip actions to one operator output
// Assumes: generator level comes from same clock domain
// Notes:   toggle inverts the generator level while trip holds
`timescale 1ns/100ps
`default_nettype none
module pftc_trip_out (
    input  wire logic       gen_in,       // generator level
    input  wire logic       count_up_in,  // timer direction
    input  wire logic       cyc_on_in,    // cycle trip in force
    input  wire logic       ost_on_in,    // one-shot trip in force
    input  wire logic [7:0] act_in,       // ost dn,up ; cyc dn,up
    output logic            out_out       // forced level
);
    function automatic logic apply(input logic [1:0] a, input logic g);
        case (pftc_pkg::pftc_act_t'(a))
            pftc_pkg::PFTC_ACT_LOW:  apply = 1'b0;
            pftc_pkg::PFTC_ACT_HIGH: apply = 1'b1;
            pftc_pkg::PFTC_ACT_TOG:  apply = ~g;
            default:                 apply = g;
        endcase
    endfunction : apply

    always_comb
    begin
        // one-shot outranks cycle trip and generator
        if (ost_on_in)
            out_out = apply(count_up_in ? act_in[5:4] : act_in[7:6], gen_in);
        else if (cyc_on_in)
            out_out = apply(count_up_in ? act_in[1:0] : act_in[3:2], gen_in);
        else
            out_out = gen_in;
    end
endmodule : pftc_trip_out
`default_nettype wire

// >>> hdl/pftc_trip_capture.sv
// Purpose: fault trip handling and three-channel input capture, apb slave
// Assumes: 10 MHz mclk_in serves as both pwm and bus clock
// Notes:   pins pass two flops; outputs registered
//
// Decided for this implementation: the register offsets and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
`include "pftc_defines.svh"
////////////////////////////////////////////////////////////////////////////
module pftc_trip_capture #(
    parameter int NCH = 3                     // capture channels
) (
    input  wire logic        mclk_in,            // 10 MHz clock
    input  wire logic        rst_n_in,           // async reset, low
    input  wire logic        psel_in,            // apb select
    input  wire logic        penable_in,         // apb enable
    input  wire logic        pwrite_in,          // apb direction
    input  wire logic [11:0] paddr_in,           // apb byte address
    input  wire logic [31:0] pwdata_in,          // apb write data
    output logic             pready_out,         // apb ready
    output logic [31:0]      prdata_out,         // apb read data
    output logic             pslverr_out,        // apb error
    input  wire logic [2:0]  fault_input_in,     // fault pins
    input  wire logic [2:0]  capture_input_in,   // capture pins
    input  wire logic        gen_a_in,           // generator level a
    input  wire logic        gen_b_in,           // generator level b
    input  wire logic        count_up_in,        // pwm timer counting up
    input  wire logic        timer_at_zero_event_in,   // timer zero pulse
    input  wire logic        timer_at_period_event_in, // timer period pulse
    input  wire logic        pwm_sync_in,        // pwm timer sync-out
    input  wire logic        periph_sync_in,     // peripheral sync pin
    output logic             operator_out_a_out, // operator output a
    output logic             operator_out_b_out  // operator output b
);
    logic [2:0]  flt_s1_r, flt_s2_r, cap_s1_r, cap_s2_r, psy_s_r;
    logic [31:0] cfg_r, cfg_nxt;          // trip enables, release, clear
    logic [31:0] act_r, act_nxt;          // action fields
    logic [31:0] tcfg_r, tcfg_nxt;
    logic [31:0] phase_r, phase_nxt;
    logic [31:0] ccfg_r [NCH], ccfg_nxt [NCH];
    logic [31:0] timer_r, timer_nxt;
    logic        cyc_on_r, cyc_on_nxt, ost_on_r, ost_on_nxt;
    logic        clr_seen_r, clr_seen_nxt;
    logic [2:0]  cyc_ev_r, cyc_ev_nxt, ost_ev_r, ost_ev_nxt;
    logic [NCH-1:0] cap_ev_r, cap_ev_nxt;
    logic [2:0]  sw_cyc, sw_ost;
    logic        sw_sync;
    logic [31:0] rdata_nxt;
    logic        err_nxt, rdy_r, rdy_nxt, oa_r, ob_r, oa_c, ob_c;
    logic [2:0]  cyc_hit, ost_hit;
    logic        rel_pt, wr, acc;
    logic [NCH-1:0] ch_ev, ch_fall;
    logic [31:0] ch_ts [NCH];

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    always_ff @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            flt_s1_r <= 3'h0;
            flt_s2_r <= 3'h0;
            cap_s1_r <= 3'h0;
            cap_s2_r <= 3'h0;
            psy_s_r  <= 3'h0;
        end
        else
        begin
            flt_s1_r <= fault_input_in;
            flt_s2_r <= flt_s1_r;
            cap_s1_r <= capture_input_in;
            cap_s2_r <= cap_s1_r;
            psy_s_r  <= {psy_s_r[1], psy_s_r[0], periph_sync_in};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // apb access, one wait state
    assign acc = psel_in && penable_in && !rdy_r;
    assign wr  = acc && pwrite_in;

    function automatic logic is_ch(input logic [11:0] a, input int k);
        is_ch = (a == 12'(`PFTC_OFF_CAP_CH0CFG + 4 * k));
    endfunction : is_ch

    function automatic logic is_ts(input logic [11:0] a, input int k);
        is_ts = (a == 12'(`PFTC_OFF_CAP_TS0 + 4 * k));
    endfunction : is_ts

    // software trigger strobes: written bits are one-cycle pulses
    always_comb
    begin
        sw_cyc  = 3'h0;
        sw_ost  = 3'h0;
        sw_sync = 1'b0;
        if (wr && paddr_in == `PFTC_OFF_TRIP_SW)
        begin
            sw_cyc = pwdata_in[2:0];
            sw_ost = pwdata_in[6:4];
        end
        if (wr && paddr_in == `PFTC_OFF_CAP_TCFG)
            sw_sync = pwdata_in[`PFTC_TCFG_SWSY_BIT];
    end

    ////////////////////////////////////////////////////////////////////////
    // fault trip state
    always_comb
    begin
        cyc_hit = (flt_s2_r | sw_cyc) & cfg_r[2:0];
        ost_hit = (flt_s2_r | sw_ost) & cfg_r[5:3];
        case (pftc_pkg::pftc_rel_t'(cfg_r[7:6]))
            pftc_pkg::PFTC_REL_ZERO_UP:
                rel_pt = timer_at_zero_event_in && count_up_in;
            pftc_pkg::PFTC_REL_ZERO_DOWN:
                rel_pt = timer_at_zero_event_in && !count_up_in;
            pftc_pkg::PFTC_REL_PER_UP:
                rel_pt = timer_at_period_event_in && count_up_in;
            default:
                rel_pt = timer_at_period_event_in && !count_up_in;
        endcase
        cyc_on_nxt = cyc_on_r;
        if (|cyc_hit)
            cyc_on_nxt = 1'b1;
        else if (rel_pt)
            cyc_on_nxt = 1'b0;
        // a fault still present at the release point keeps it in force
        if (|cyc_hit && rel_pt)
            cyc_on_nxt = 1'b1;
        clr_seen_nxt = cfg_r[`PFTC_CFG_CLR_BIT];
        ost_on_nxt   = ost_on_r;
        if (clr_seen_r != cfg_r[`PFTC_CFG_CLR_BIT])
            ost_on_nxt = 1'b0;
        if (|ost_hit)
            ost_on_nxt = 1'b1;
        cyc_ev_nxt = cyc_ev_r | cyc_hit;
        ost_ev_nxt = ost_ev_r | ost_hit;
        cap_ev_nxt = cap_ev_r | ch_ev;
        if (wr && paddr_in == `PFTC_OFF_TRIP_STAT)
        begin
            cyc_ev_nxt = (cyc_ev_r & ~pwdata_in[2:0]) | cyc_hit;
            ost_ev_nxt = (ost_ev_r & ~pwdata_in[6:4]) | ost_hit;
        end
        if (wr && paddr_in == `PFTC_OFF_CAP_STAT)
            cap_ev_nxt = (cap_ev_r & ~pwdata_in[NCH-1:0]) | ch_ev;
    end

    ////////////////////////////////////////////////////////////////////////
    // capture timer
    always_comb
    begin
        timer_nxt = timer_r;
        if (tcfg_r[`PFTC_TCFG_EN_BIT])
            timer_nxt = timer_r + 32'h0000_0001;
        if (sw_sync || (tcfg_r[`PFTC_TCFG_SYEN_BIT] &&
            (pwm_sync_in || (psy_s_r[1] && !psy_s_r[2]))))
            timer_nxt = phase_r;
    end

    ////////////////////////////////////////////////////////////////////////
    // register writes and read mux
    always_comb
    begin
        cfg_nxt   = cfg_r;
        act_nxt   = act_r;
        tcfg_nxt  = tcfg_r;
        phase_nxt = phase_r;
        for (int k = 0; k < NCH; k++)
        begin
            ccfg_nxt[k] = ccfg_r[k];
            ccfg_nxt[k][`PFTC_CCFG_SWCAP_BIT] = 1'b0;
        end
        tcfg_nxt[`PFTC_TCFG_SWSY_BIT] = 1'b0;
        rdata_nxt = `PFTC_RST_WORD;
        err_nxt   = 1'b0;
        rdy_nxt   = acc;
        if (paddr_in == `PFTC_OFF_TRIP_CFG)
        begin
            rdata_nxt = cfg_r;
            if (wr)
                cfg_nxt = {23'h0, pwdata_in[8:0]};
        end
        else if (paddr_in == `PFTC_OFF_TRIP_ACT)
        begin
            rdata_nxt = act_r;
            if (wr)
                act_nxt = {16'h0, pwdata_in[15:0]};
        end
        else if (paddr_in == `PFTC_OFF_TRIP_SW)
            rdata_nxt = `PFTC_RST_WORD;
        else if (paddr_in == `PFTC_OFF_TRIP_STAT)
            rdata_nxt = {22'h0, ost_on_r, cyc_on_r, 1'b0,
                         ost_ev_r, 1'b0, cyc_ev_r};
        else if (paddr_in == `PFTC_OFF_CAP_TCFG)
        begin
            rdata_nxt = tcfg_r;
            if (wr)
                tcfg_nxt = {30'h0, pwdata_in[1:0]};
        end
        else if (paddr_in == `PFTC_OFF_CAP_PHASE)
        begin
            rdata_nxt = phase_r;
            if (wr)
                phase_nxt = pwdata_in;
        end
        else if (paddr_in == `PFTC_OFF_CAP_STAT)
            rdata_nxt = {24'h0, 1'b0, ch_fall, 1'b0, cap_ev_r};
        else if (paddr_in == `PFTC_OFF_CAP_TIMER)
            rdata_nxt = timer_r;
        else
        begin
            err_nxt = 1'b1;
            for (int k = 0; k < NCH; k++)
            begin
                if (is_ch(paddr_in, k))
                begin
                    err_nxt     = 1'b0;
                    rdata_nxt   = ccfg_r[k];
                    if (wr)
                        ccfg_nxt[k] = {15'h0, pwdata_in[16:0]};
                end
                else if (is_ts(paddr_in, k))
                begin
                    err_nxt   = 1'b0;
                    rdata_nxt = ch_ts[k];
                end
            end
        end
        if (!acc)
            err_nxt = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // registers
    always_ff @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            cfg_r       <= `PFTC_RST_WORD;
            act_r       <= `PFTC_RST_WORD;
            tcfg_r      <= `PFTC_RST_WORD;
            phase_r     <= `PFTC_RST_WORD;
            for (int k = 0; k < NCH; k++)
                ccfg_r[k] <= `PFTC_RST_WORD;
            timer_r     <= `PFTC_RST_WORD;
            cyc_on_r    <= 1'b0;
            ost_on_r    <= 1'b0;
            clr_seen_r  <= 1'b0;
            cyc_ev_r    <= 3'h0;
            ost_ev_r    <= 3'h0;
            cap_ev_r    <= '0;
            rdy_r       <= 1'b0;
            prdata_out  <= `PFTC_RST_WORD;
            pslverr_out <= 1'b0;
            oa_r        <= 1'b0;
            ob_r        <= 1'b0;
        end
        else
        begin
            cfg_r       <= cfg_nxt;
            act_r       <= act_nxt;
            tcfg_r      <= tcfg_nxt;
            phase_r     <= phase_nxt;
            for (int k = 0; k < NCH; k++)
                ccfg_r[k] <= ccfg_nxt[k];
            timer_r     <= timer_nxt;
            cyc_on_r    <= cyc_on_nxt;
            ost_on_r    <= ost_on_nxt;
            clr_seen_r  <= clr_seen_nxt;
            cyc_ev_r    <= cyc_ev_nxt;
            ost_ev_r    <= ost_ev_nxt;
            cap_ev_r    <= cap_ev_nxt;
            rdy_r       <= rdy_nxt;
            prdata_out  <= rdata_nxt;
            pslverr_out <= err_nxt;
            oa_r        <= oa_c;
            ob_r        <= ob_c;
        end
    end

    assign pready_out         = rdy_r;
    assign operator_out_a_out = oa_r;
    assign operator_out_b_out = ob_r;

    ////////////////////////////////////////////////////////////////////////
    // capture channels
    for (genvar g = 0; g < NCH; g++)
    begin : g_cap
        pftc_cap_if cif ();
        assign cif.enable     = ccfg_r[g][`PFTC_CCFG_EN_BIT];
        assign cif.invert     = ccfg_r[g][`PFTC_CCFG_INV_BIT];
        assign cif.on_rise    = ccfg_r[g][`PFTC_CCFG_RISE_BIT];
        assign cif.on_fall    = ccfg_r[g][`PFTC_CCFG_FALL_BIT];
        assign cif.prescale   =
            ccfg_r[g][`PFTC_CCFG_PRE_LSB+7:`PFTC_CCFG_PRE_LSB];
        assign cif.sw_capture = ccfg_r[g][`PFTC_CCFG_SWCAP_BIT];
        assign ch_ev[g]       = cif.event_pulse;
        assign ch_fall[g]     = cif.edge_falling;
        assign ch_ts[g]       = cif.stamp;
        pftc_cap_chan u_chan (
            .mclk_in  (mclk_in),
            .rst_n_in (rst_n_in),
            .cap_in   (cap_s2_r[g]),
            .timer_in (timer_r),
            .cfg      (cif.chan)
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // output forcing: trip state next-value used so action is immediate
    pftc_trip_out u_out_a (
        .gen_in      (gen_a_in),
        .count_up_in (count_up_in),
        .cyc_on_in   (cyc_on_nxt),
        .ost_on_in   (ost_on_nxt),
        .act_in      ({act_r[11:8], act_r[3:0]}),
        .out_out     (oa_c)
    );
    pftc_trip_out u_out_b (
        .gen_in      (gen_b_in),
        .count_up_in (count_up_in),
        .cyc_on_in   (cyc_on_nxt),
        .ost_on_in   (ost_on_nxt),
        .act_in      ({act_r[15:12], act_r[7:4]}),
        .out_out     (ob_c)
    );
endmodule : pftc_trip_capture
`default_nettype wire

// >>> testbench/pftc_trip_capture_chk.sv
// Purpose: apb timing checks of the trip/capture block
// Assumes: one clock, one wait state
// Notes:   bound to the top module
`timescale 1ns/100ps
`default_nettype none
module pftc_trip_capture_chk (
    input  wire logic        mclk_in,     // clock
    input  wire logic        rst_n_in,    // async reset, low
    input  wire logic        psel_in,     // apb select
    input  wire logic        penable_in,  // apb enable
    input  wire logic        pwrite_in,   // apb direction
    input  wire logic [11:0] paddr_in,    // apb address
    input  wire logic        pready_out,  // apb ready
    input  wire logic [31:0] prdata_out,  // apb read data
    input  wire logic        pslverr_out  // apb error
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);
    logic acc;
    assign acc = psel_in && penable_in && !pready_out;
    a_ready_wait: assert property (acc |=> pready_out)
        else $error("ready missing");
    a_ready_pulse: assert property (pready_out |=> !pready_out)
        else $error("ready too long");
    a_ready_cause: assert property ($rose(pready_out) |-> $past(acc))
        else $error("ready without access");
    a_err_ready: assert property (pslverr_out |-> pready_out)
        else $error("error without ready");
    a_err_unmapped: assert property (acc && paddr_in > 12'h034 |=> pslverr_out)
        else $error("unmapped not refused");
    a_map_ok: assert property (acc && paddr_in == 12'h000 |=> !pslverr_out)
        else $error("mapped refused");
    a_wo_zero: assert property (acc && !pwrite_in && paddr_in == 12'h008
        |=> prdata_out == 32'h0) else $error("write-only not zero");
    a_err_zero: assert property (acc && !pwrite_in && paddr_in > 12'h034
        |=> prdata_out == 32'h0) else $error("refused read not zero");
    c_err: cover property (pslverr_out);
    c_wr: cover property (acc && pwrite_in ##1 pready_out);
    c_ts: cover property (pready_out && !pwrite_in && paddr_in == 12'h024);
endmodule : pftc_trip_capture_chk
bind pftc_trip_capture pftc_trip_capture_chk u_chk (.mclk_in(mclk_in),
    .rst_n_in(rst_n_in), .psel_in(psel_in), .penable_in(penable_in),
    .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pready_out(pready_out),
    .prdata_out(prdata_out), .pslverr_out(pslverr_out));
`default_nettype wire

// >>> testbench/pftc_pins.sv
// Purpose: pad-side model of fault and capture sources
// Assumes: levels requested by the bench
// Notes:   registered so every pulse lasts whole cycles
`timescale 1ns/100ps
`default_nettype none
module pftc_pins (
    input  wire logic       mclk_in,  // clock
    input  wire logic [5:0] req_in,   // capture[5:3], fault[2:0]
    output logic      [5:0] pins_out  // pad levels
);
    initial pins_out = 6'h00;
    always @(posedge mclk_in) pins_out <= req_in;
endmodule : pftc_pins
`default_nettype wire

// >>> testbench/tb_pftc_trip_capture.sv
// Purpose: self-checking bench of the trip/capture block
// Assumes: apb with one wait state
// Notes:   sync and period pulses driven by the bench
`timescale 1ns/100ps
`default_nettype none
module tb_pftc_trip_capture;
    logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic ga = 1'b0, gb = 1'b0, up = 1'b1, tz = 1'b0, rdy, er, oa, ob;
    logic tp = 1'b0, ps = 1'b0, pp = 1'b0;
    logic [11:0] pa = 12'h000;
    logic [31:0] pwd = 32'h0, prd, rd;
    logic [5:0]  req = 6'h00, pins;
    int          n_fail = 0, samples_checked = 0, k;
    logic [11:0] ra [5] = '{12'h000, 12'h004, 12'h014, 12'h018, 12'h040};
    logic [31:0] rw [5] = '{32'hC7, 32'hA5C3, 32'h1234, 32'hFF0D, 32'h5A};
    logic [31:0] rx [5] = '{32'hC7, 32'hA5C3, 32'h1234, 32'hFF0D, 32'h0};
    always #50 clk = ~clk;
    pftc_pins u_pins (.mclk_in(clk), .req_in(req), .pins_out(pins));
    pftc_trip_capture DUT (.mclk_in(clk), .rst_n_in(rst_n), .psel_in(psel),
        .penable_in(pen), .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pwd),
        .pready_out(rdy), .prdata_out(prd), .pslverr_out(er),
        .fault_input_in(pins[2:0]), .capture_input_in(pins[5:3]),
        .gen_a_in(ga), .gen_b_in(gb), .count_up_in(up),
        .timer_at_zero_event_in(tz), .timer_at_period_event_in(tp),
        .pwm_sync_in(ps), .periph_sync_in(pp),
        .operator_out_a_out(oa), .operator_out_b_out(ob));
    ////////////////////////////////////////////////////////////////////////
    task stop_test();
        $display("checks %0d errors %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : stop_test
    task chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task outs(input logic a, input logic b);
        chk({30'h0, oa, ob}, {30'h0, a, b});
    endtask : outs
    task tick(input int c);
        repeat (c) @(posedge clk);
    endtask : tick
    // no fixed latency assumed: poll ready, bounded by the watchdog
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        {psel, pwr, pa, pwd} <= {1'b1, w, a, d};
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (rdy !== 1'b1);
        rd = prd;
        {psel, pen} <= 2'b00;
    endtask : apb
    task rdc(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask : rdc
    task zero();
        tz <= 1'b1;
        tick(1);
        tz <= 1'b0;
        tick(3);
    endtask : zero
    initial
    begin
        #1000000 n_fail++;
        stop_test();
    end
    initial
    begin
        tick(20);
        outs(1'b0, 1'b0);
        rst_n <= 1'b1;
        rdc(12'h00C, 32'h0);
        for (k = 0; k < 5; k++)
        begin
            apb(1'b1, ra[k], rw[k]);
            rdc(ra[k], rx[k]);
            chk({31'h0, er}, {31'h0, k == 4});
        end
        apb(1'b1, 12'h004, 32'h1E);
        apb(1'b1, 12'h000, 32'h01);
        {gb, req} <= {1'b1, 6'h01};
        tick(6);
        outs(1'b1, 1'b0);
        up <= 1'b0;
        tick(3);
        outs(1'b1, 1'b1);
        rdc(12'h00C, 32'h0101);
        req <= 6'h00;
        tick(4);
        zero();
        outs(1'b1, 1'b1);
        up <= 1'b1;
        zero();
        outs(1'b0, 1'b1);
        rdc(12'h00C, 32'h0001);
        apb(1'b1, 12'h00C, 32'h1);
        apb(1'b1, 12'h004, 32'h3201);
        apb(1'b1, 12'h000, 32'h12);
        req <= 6'h02;
        tick(2);
        req <= 6'h00;
        tick(6);
        outs(1'b1, 1'b0);
        zero();
        outs(1'b1, 1'b0);
        rdc(12'h00C, 32'h0222);
        apb(1'b1, 12'h000, 32'h132);
        tick(3);
        outs(1'b0, 1'b1);
        apb(1'b1, 12'h008, 32'h40);
        tick(3);
        outs(1'b1, 1'b0);
        rdc(12'h008, 32'h0);
        apb(1'b1, 12'h014, 32'hABCD);
        apb(1'b1, 12'h010, 32'h4);
        rdc(12'h034, 32'hABCD);
        apb(1'b1, 12'h018, 32'h10005);
        rdc(12'h024, 32'hABCD);
        req <= 6'h10;
        apb(1'b1, 12'h01C, 32'h7);
        apb(1'b1, 12'h020, 32'h9);
        req <= 6'h20;
        tick(6);
        req <= 6'h00;
        tick(6);
        rdc(12'h028, 32'hABCD);
        rdc(12'h02C, 32'hABCD);
        rdc(12'h030, 32'h47);
        apb(1'b1, 12'h030, 32'h7);
        apb(1'b1, 12'h010, 32'h1);
        apb(1'b1, 12'h018, 32'h105);
        req <= 6'h08;
        tick(6);
        rdc(12'h030, 32'h40);
        req <= 6'h00;
        tick(6);
        rdc(12'h030, 32'h41);
        apb(1'b0, 12'h024, 32'h0);
        chk({31'h0, rd > 32'hABCD}, 32'h1);
        apb(1'b1, 12'h000, 32'h0C2);
        apb(1'b1, 12'h008, 32'h2);
        tp <= 1'b1;
        tick(1);
        tp <= 1'b0;
        rdc(12'h00C, 32'h0162);
        {up, tp} <= 2'b01;
        tick(1);
        tp <= 1'b0;
        rdc(12'h00C, 32'h0062);
        apb(1'b1, 12'h014, 32'h5A5A);
        apb(1'b1, 12'h010, 32'h2);
        ps <= 1'b1;
        tick(1);
        ps <= 1'b0;
        rdc(12'h034, 32'h5A5A);
        apb(1'b1, 12'h014, 32'h1111);
        pp <= 1'b1;
        tick(4);
        rdc(12'h034, 32'h1111);
        // second reset in mid-run: trips, flags and outputs go idle
        rst_n <= 1'b0;
        tick(2);
        outs(1'b0, 1'b0);
        rst_n <= 1'b1;
        rdc(12'h00C, 32'h0);
        outs(1'b0, 1'b1);
        stop_test();
    end
endmodule : tb_pftc_trip_capture
`default_nettype wire
